// ===== tb/idp_host_model.sv
// Host controller model: drives chip select, serial clock and data in, mode 0.
// Assumes the core clock; serial clock period is 16 core clocks (160 ns).
`timescale 1ns/1ps
module idp_host_model (
   // Clock
   input  wire logic i_core_clk,
   // Device answer
   input  wire logic i_miso,
   input  wire logic i_miso_oe,
   // Link pins
   output logic      o_cs_n,
   output logic      o_sclk,
   output logic      o_mosi
);
   initial begin
      o_cs_n = 1'b1;
      o_sclk = 1'b0;
      o_mosi = 1'b0;
   end

   // Sends nbits of tx MSB first, samples the answer on each rising clock
   task automatic xfer(input logic [95:0] tx, input int nbits,
                       output logic [63:0] rx, output logic oe_seen);
      rx = '0;
      oe_seen = 1'b0;
      @(posedge i_core_clk) o_cs_n <= 1'b0;
      // Low half: data set mid-way; high half: 8 core clocks
      for (int i = 0; i < nbits; i++) begin
         repeat (4) @(posedge i_core_clk);
         o_mosi <= tx[95 - i];
         repeat (4) @(posedge i_core_clk);
         o_sclk <= 1'b1;
         rx = {rx[62:0], i_miso};
         oe_seen = oe_seen | i_miso_oe;
         repeat (8) @(posedge i_core_clk);
         o_sclk <= 1'b0;
      end
      repeat (8) @(posedge i_core_clk);
      o_cs_n <= 1'b1;
      // Idle data line toggles for 6 core clocks so no stale level is mistaken for data
      repeat (6) @(posedge i_core_clk) o_mosi <= ~o_mosi;
   endtask : xfer
endmodule : idp_host_model

// ===== tb/idp_id_page_access_props.sv
// Checker for the identification page engine, bound to its top module.
// Assumes one core clock domain with synchronous active-low reset.
`timescale 1ns/1ps
module idp_id_page_access_props #(
   parameter int P_WRITE_CYCLES = 500
) (
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   input wire logic i_spi_cs_n,
   input wire logic i_spi_clk,
   input wire logic o_spi_miso,
   input wire logic o_spi_miso_oe,
   input wire logic o_write_enable_latch,
   input wire logic o_write_in_progress_flag,
   input wire logic o_id_locked
);
   int busy_cnt_r = 0;
   always_ff @(posedge i_core_clk) begin
      busy_cnt_r <= o_write_in_progress_flag ? busy_cnt_r + 1 : 0;
   end
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_reset_n);

   a_reset_clears:
      assert property (disable iff (1'b0) !i_reset_n |=> !o_write_enable_latch &&
         !o_write_in_progress_flag && !o_id_locked && !o_spi_miso_oe)
      else $error("state not cleared by reset");
   a_busy_length:
      assert property ($fell(o_write_in_progress_flag) |->
         busy_cnt_r >= P_WRITE_CYCLES - 1 && busy_cnt_r <= P_WRITE_CYCLES + 1)
      else $error("write cycle length wrong");
   a_busy_bounded:
      assert property (busy_cnt_r <= P_WRITE_CYCLES + 1)
      else $error("write cycle too long");
   a_wip_needs_wel:
      assert property ($rose(o_write_in_progress_flag) |->
         $past(o_write_enable_latch) || $past(o_write_enable_latch, 2))
      else $error("cycle started without write enable");
   a_wel_drops:
      assert property ($rose(o_write_in_progress_flag) |-> ##[0:1] !o_write_enable_latch)
      else $error("write enable kept after cycle start");
   a_lock_after_cycle:
      assert property ($rose(o_id_locked) |->
         $past(o_write_in_progress_flag) || $past(o_write_in_progress_flag, 2))
      else $error("lock set without write cycle");
   a_lock_sticky:
      assert property (o_id_locked |=> o_id_locked)
      else $error("lock flag cleared");
   a_oe_ends:
      assert property (i_spi_cs_n [*5] |-> !o_spi_miso_oe)
      else $error("output driven while deselected");
   a_miso_quiet:
      assert property (!o_spi_miso_oe |-> !o_spi_miso)
      else $error("data out not low while idle");
   a_miso_steady:
      assert property (i_spi_clk && $past(i_spi_clk, 3) |-> $stable(o_spi_miso))
      else $error("data out moved while clock high");
endmodule : idp_id_page_access_props

bind idp_id_page_access idp_id_page_access_props #(.P_WRITE_CYCLES(P_WRITE_CYCLES)) u_props (
   .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_spi_cs_n(i_spi_cs_n),
   .i_spi_clk(i_spi_clk), .o_spi_miso(o_spi_miso), .o_spi_miso_oe(o_spi_miso_oe),
   .o_write_enable_latch(o_write_enable_latch),
   .o_write_in_progress_flag(o_write_in_progress_flag), .o_id_locked(o_id_locked));

// ===== tb/testbench.sv
// Self-checking bench for the identification page engine.
// Assumes the host model drives the link; protect bits are driven here.
`timescale 1ns/1ps
module testbench;
   import idp_pkg::*;
   localparam int P_WC = 1500;
   logic        clk;
   logic        rst_n;
   logic        bph;
   logic        bpl;
   logic        swd;
   wire         cs_n, sclk, mosi, miso, oe, write_enable_latch, write_in_progress_flag, lck;
   int          errors;
   int          num_checks;
   int          seed;
   logic [63:0] rx;
   logic        oes;
   logic [23:0] d;

   idp_host_model host (.i_core_clk(clk), .i_miso(miso), .i_miso_oe(oe),
      .o_cs_n(cs_n), .o_sclk(sclk), .o_mosi(mosi));
   idp_id_page_access #(.P_WRITE_CYCLES(P_WC)) DUT (.i_core_clk(clk), .i_reset_n(rst_n),
      .i_spi_cs_n(cs_n), .i_spi_clk(sclk), .i_spi_mosi(mosi), .o_spi_miso(miso),
      .o_spi_miso_oe(oe), .i_status_write_disable_bit(swd), .i_block_protect_high(bph),
      .i_block_protect_low(bpl), .o_write_enable_latch(write_enable_latch),
      .o_write_in_progress_flag(write_in_progress_flag), .o_id_locked(lck));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic stop_test;
      if (errors == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : stop_test

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // Random upper address bits, chosen page select and byte position
   function automatic logic [23:0] ad(input logic [7:0] lo, input logic sel);
      logic [23:0] r;
      r = 24'($random(seed));
      r[10] = sel;
      r[7:0] = lo;
      return r;
   endfunction : ad

   task automatic fr(input logic [7:0] c, input logic [23:0] a, input logic [63:0] dt,
                     input int nb);
      host.xfer({c, a, dt}, nb, rx, oes);
      repeat (2) @(posedge clk);
   endtask : fr

   task automatic set_write_latch_cmd;
      fr(OP_SET_WRITE_LATCH, 24'h0, 64'h0, 8);
   endtask : set_write_latch_cmd

   task automatic wait_idle;
      for (int k = 0; k < P_WC + 100; k++) begin
         if (write_in_progress_flag === 1'b0) break;
         @(posedge clk);
      end
      check({7'h0, write_in_progress_flag}, 8'h00);
   endtask : wait_idle

   initial begin
      seed = 54221;
      errors = 0;
      num_checks = 0;
      rst_n = 1'b0;
      bph = 1'b0;
      bpl = 1'b0;
      swd = 1'b0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      swd <= 1'($random(seed));
      repeat (4) @(posedge clk);
      check({5'h0, write_enable_latch, write_in_progress_flag, lck}, 8'h00);
      fr(OP_ID_READ, ad(8'($random(seed)), 1'b1), 64'h0, 48);
      check(rx[15:8], 8'h00);
      check(rx[7:0], 8'h00);
      check({7'h0, oes}, 8'h01);
      fr(OP_ID_READ, ad(8'($random(seed)) & 8'h7f, 1'b0), 64'h0, 56);
      check(rx[23:16], ERASED_BYTE);
      check(rx[15:8], ERASED_BYTE);
      check(rx[7:0], ERASED_BYTE);
      d = 24'($random(seed));
      fr(OP_ID_WRITE, ad(8'hfe, 1'b0), {d, 40'h0}, 56);
      check({7'h0, write_in_progress_flag}, 8'h00);
      set_write_latch_cmd();
      check({7'h0, write_enable_latch}, 8'h01);
      fr(OP_ID_WRITE, ad(8'hfe, 1'b0), {d, 40'h0}, 56);
      check({6'h0, write_in_progress_flag, write_enable_latch}, 8'h02);
      fr(OP_ID_READ, ad(8'hfe, 1'b0), 64'h0, 48);
      check({7'h0, oes}, 8'h00);
      wait_idle();
      fr(OP_ID_READ, ad(8'hfe, 1'b0), 64'h0, 48);
      check(rx[15:8], d[23:16]);
      check(rx[7:0], d[15:8]);
      fr(OP_ID_READ, ad(8'h00, 1'b0), 64'h0, 40);
      check(rx[7:0], d[7:0]);
      for (int k = 0; k < 3; k++) begin
         bph <= (k == 1);
         bpl <= (k == 1);
         set_write_latch_cmd();
         fr(OP_ID_WRITE, ad(8'($random(seed)), 1'b1),
            {(k == 2) ? 8'hfd : 8'h02, 56'h0}, (k == 0) ? 39 : 40);
         check({6'h0, write_in_progress_flag, lck}, 8'h00);
      end
      bph <= 1'b0;
      bpl <= 1'($random(seed));
      set_write_latch_cmd();
      fr(OP_ID_WRITE, ad(8'($random(seed)), 1'b1), {8'($random(seed)) | 8'h02, 56'h0}, 40);
      check({7'h0, write_in_progress_flag}, 8'h01);
      wait_idle();
      repeat (2) @(posedge clk);
      check({7'h0, lck}, 8'h01);
      fr(OP_ID_READ, ad(8'($random(seed)), 1'b1), 64'h0, 48);
      check(rx[15:8], 8'h01);
      check(rx[7:0], 8'h01);
      set_write_latch_cmd();
      fr(OP_ID_WRITE, ad(8'hfe, 1'b0), {~d[23:16], 56'h0}, 40);
      check({7'h0, write_in_progress_flag}, 8'h00);
      fr(OP_ID_READ, ad(8'hfe, 1'b0), 64'h0, 40);
      check(rx[7:0], d[23:16]);
      stop_test();
   end

   initial begin
      repeat (60000) @(posedge clk);
      errors++;
      stop_test();
   end
endmodule : testbench

// ===== verilog/idp_id_page_access.sv
// Instruction engine for the identification page: read, write, lock status, lock.
// Assumes an SPI mode 0 host; pins are sampled by the 100 MHz core clock.
`timescale 1ns/1ps
module idp_id_page_access #(
   parameter int P_WRITE_CYCLES = idp_pkg::WRITE_CYCLES
) (
   // Clock and reset
   input  wire logic  i_core_clk,
   input  wire logic  i_reset_n,
   // Serial link pins
   input  wire logic  i_spi_cs_n,
   input  wire logic  i_spi_clk,
   input  wire logic  i_spi_mosi,
   output logic       o_spi_miso,
   output logic       o_spi_miso_oe,
   // Non-volatile status bits held outside
   input  wire logic  i_status_write_disable_bit,
   input  wire logic  i_block_protect_high,
   input  wire logic  i_block_protect_low,
   // Status
   output logic       o_write_enable_latch,
   output logic       o_write_in_progress_flag,
   output logic       o_id_locked
);
   import idp_pkg::*;

   typedef struct packed {
      logic [2:0]            sync1;
      logic [2:0]            sync2;
      logic                  clk_prev;
      logic                  cs_prev;
      idp_phase_e            phase;
      logic [4:0]            in_cnt;
      logic [2:0]            out_cnt;
      logic [ADDR_BITS-1:0]  sh;
      logic [7:0]            cmd;
      logic [7:0]            ptr;
      logic [7:0]            tx;
      logic                  miso;
      logic                  oe;
      logic [1:0]            nbytes;
      logic                  lock_op;
      logic                  lock_data_ok;
      logic                  pend_lock;
      logic                  write_enable_latch;
      logic                  write_in_progress_flag;
      logic                  locked;
      logic [31:0]           wcnt;
   } idp_state_s;

   idp_state_s state_r;
   idp_state_s state_nxt;

   idp_mem_if mem_if ();

   idp_page_store u_store (
      .i_core_clk (i_core_clk),
      .i_reset_n  (i_reset_n),
      .mem_if     (mem_if)
   );

   logic       cs_n;
   logic       sclk;
   logic       mosi;
   logic       sclk_rise;
   logic       sclk_fall;
   logic       cs_fall;
   logic       cs_rise;
   logic [7:0] in_byte;
   logic       full_protect;
   logic       wr_done;

   always_comb begin
      cs_n         = state_r.sync2[2];
      sclk         = state_r.sync2[1];
      mosi         = state_r.sync2[0];
      sclk_rise    = sclk && !state_r.clk_prev;
      sclk_fall    = !sclk && state_r.clk_prev;
      // Synchronisers reset low: a fall needs a real high first
      cs_fall      = !cs_n && state_r.cs_prev; // RULE16
      cs_rise      = cs_n && !state_r.cs_prev;
      in_byte      = {state_r.sh[6:0], mosi};
      full_protect = i_block_protect_high && i_block_protect_low;
      wr_done      = state_r.write_in_progress_flag && state_r.wcnt == 32'(P_WRITE_CYCLES - 1);
   end

   always_comb begin
      state_nxt          = state_r;
      state_nxt.sync1    = {i_spi_cs_n, i_spi_clk, i_spi_mosi};
      state_nxt.sync2    = state_r.sync1;
      state_nxt.clk_prev = sclk;
      state_nxt.cs_prev  = cs_n;

      mem_if.wr_en     = 1'b0;
      mem_if.wr_addr   = state_r.ptr;
      mem_if.wr_data   = in_byte;
      mem_if.stage_clr = 1'b0;
      mem_if.commit    = 1'b0;
      mem_if.rd_addr   = state_r.ptr;

      // Self-timed write cycle
      if (state_r.write_in_progress_flag) begin
         state_nxt.wcnt = state_r.wcnt + 32'd1;
         if (wr_done) begin
            state_nxt.write_in_progress_flag = 1'b0; // RULE20
            if (state_r.pend_lock) begin
               state_nxt.locked = 1'b1; // RULE1
            end else begin
               mem_if.commit = 1'b1; // RULE1
            end
         end
      end

      if (cs_fall) begin
         state_nxt.phase  = PH_CMD;
         state_nxt.in_cnt = 5'd0;
      end else if (cs_rise) begin
         state_nxt.phase = PH_IDLE; // RULE5
         state_nxt.oe    = 1'b0;
         state_nxt.miso  = 1'b0;
         if (state_r.phase == PH_WR_DATA && state_r.in_cnt == 5'd0 &&
             state_r.nbytes != 2'd0 && !state_r.write_in_progress_flag) begin
            if (!state_r.lock_op) begin
               state_nxt.write_in_progress_flag       = 1'b1; // RULE21
               state_nxt.wcnt      = 32'd0;
               state_nxt.write_enable_latch       = 1'b0;
               state_nxt.pend_lock = 1'b0;
            end else if (state_r.nbytes == 2'd1 && state_r.lock_data_ok && // RULE13
                         state_r.write_enable_latch && !full_protect) begin // RULE11 RULE15
               state_nxt.write_in_progress_flag       = 1'b1; // RULE14
               state_nxt.wcnt      = 32'd0;
               state_nxt.write_enable_latch       = 1'b0;
               state_nxt.pend_lock = 1'b1;
            end
         end
      end else if (sclk_rise && !cs_n) begin
         state_nxt.sh     = {state_r.sh[ADDR_BITS-2:0], mosi};
         state_nxt.in_cnt = state_r.in_cnt + 5'd1;
         case (state_r.phase)
            PH_CMD: begin
               if (state_r.in_cnt == 5'd7) begin
                  state_nxt.cmd    = in_byte;
                  state_nxt.in_cnt = 5'd0;
                  if (in_byte == OP_SET_WRITE_LATCH) begin
                     state_nxt.write_enable_latch   = 1'b1;
                     state_nxt.phase = PH_DISCARD;
                  end else if (in_byte == OP_ID_READ || in_byte == OP_ID_WRITE) begin
                     state_nxt.phase = PH_ADDR;
                  end else begin
                     state_nxt.phase = PH_DISCARD;
                  end
               end
            end
            PH_ADDR: begin
               if (state_r.in_cnt == 5'(ADDR_BITS - 1)) begin
                  state_nxt.in_cnt  = 5'd0;
                  state_nxt.out_cnt = 3'd0;
                  state_nxt.nbytes  = 2'd0;
                  state_nxt.ptr     = in_byte; // RULE2 RULE7
                  state_nxt.lock_op = state_r.sh[PAGE_SELECT_POS-1];
                  if (state_r.cmd == OP_ID_READ) begin
                     if (state_r.sh[PAGE_SELECT_POS-1]) begin
                        state_nxt.phase = PH_RD_LOCK; // RULE8
                        state_nxt.oe    = 1'b1;
                     end else if (state_r.write_in_progress_flag) begin
                        state_nxt.phase = PH_DISCARD; // RULE6
                     end else begin
                        state_nxt.phase = PH_RD_DATA;
                        state_nxt.oe    = 1'b1;
                     end
                  end else if (state_r.write_in_progress_flag) begin
                     state_nxt.phase = PH_DISCARD; // RULE15
                  end else if (state_r.sh[PAGE_SELECT_POS-1]) begin
                     state_nxt.phase = PH_WR_DATA; // RULE12
                  end else if (state_r.locked || !state_r.write_enable_latch) begin
                     state_nxt.phase = PH_DISCARD; // RULE21
                  end else begin
                     state_nxt.phase  = PH_WR_DATA;
                     mem_if.stage_clr = 1'b1;
                  end
               end
            end
            PH_WR_DATA: begin
               state_nxt.in_cnt = {2'b00, 3'(state_r.in_cnt[2:0] + 3'd1)};
               if (state_r.in_cnt[2:0] == 3'd7) begin
                  if (state_r.nbytes != 2'd3) begin
                     state_nxt.nbytes = state_r.nbytes + 2'd1;
                  end
                  if (state_r.lock_op) begin
                     state_nxt.lock_data_ok = in_byte[LOCK_DATA_POS]; // RULE12
                  end else begin
                     mem_if.wr_en  = 1'b1;
                     state_nxt.ptr = state_r.ptr + 8'd1; // RULE22
                  end
               end
            end
            default: begin
               state_nxt.in_cnt = 5'd0;
            end
         endcase
      end else if (sclk_fall && !cs_n &&
                   (state_r.phase == PH_RD_DATA || state_r.phase == PH_RD_LOCK)) begin
         state_nxt.out_cnt = state_r.out_cnt + 3'd1;
         if (state_r.out_cnt == 3'd0) begin
            if (state_r.phase == PH_RD_LOCK) begin
               state_nxt.miso = 1'b0;
               state_nxt.tx   = {6'h00, state_r.locked, 1'b1}; // RULE9 RULE10
            end else begin
               state_nxt.miso = mem_if.rd_data[7];
               state_nxt.tx   = {mem_if.rd_data[6:0], 1'b1};
               state_nxt.ptr  = state_r.ptr + 8'd1; // RULE3
            end
         end else begin
            state_nxt.miso = state_r.tx[7];
            state_nxt.tx   = {state_r.tx[6:0], 1'b1};
         end
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         state_r        <= '0; // RULE17
         state_r.phase  <= PH_IDLE;
         state_r.locked <= 1'b0; // RULE19
      end else begin
         state_r <= state_nxt;
      end
   end

   // Status-write-disable only matters to status writes, kept for completeness
   logic unused_swd;
   assign unused_swd = i_status_write_disable_bit; // RULE18

   assign o_spi_miso               = state_r.miso;
   assign o_spi_miso_oe            = state_r.oe;
   assign o_write_enable_latch     = state_r.write_enable_latch;
   assign o_write_in_progress_flag = state_r.write_in_progress_flag;
   assign o_id_locked              = state_r.locked;
endmodule : idp_id_page_access

// ===== verilog/idp_mem_if.sv
// Link between the instruction engine and the page storage.
// Assumes both ends run on the core clock.
`timescale 1ns/1ps
interface idp_mem_if;
   logic       wr_en;
   logic [7:0] wr_addr;
   logic [7:0] wr_data;
   logic       stage_clr;
   logic       commit;
   logic [7:0] rd_addr;
   logic [7:0] rd_data;
   modport ctrl (output wr_en, wr_addr, wr_data, stage_clr, commit, rd_addr, input rd_data);
   modport mem  (input wr_en, wr_addr, wr_data, stage_clr, commit, rd_addr, output rd_data);
endinterface : idp_mem_if

// ===== verilog/idp_page_store.sv
// Identification page storage with a staging buffer for self-timed writes.
// Assumes the engine loads the stage, then pulses commit at write cycle end.
`timescale 1ns/1ps
module idp_page_store (
   // Clock and reset
   input  wire logic  i_core_clk,
   input  wire logic  i_reset_n,
   // Engine side
   idp_mem_if.mem     mem_if
);
   import idp_pkg::*;

   logic [7:0] page_r  [PAGE_BYTES];
   logic [7:0] stage_r [PAGE_BYTES];
   logic       valid_r [PAGE_BYTES];

   for (genvar i = 0; i < PAGE_BYTES; i++) begin : g_entry
      always_ff @(posedge i_core_clk) begin
         if (!i_reset_n) begin
            page_r[i]  <= ERASED_BYTE; // RULE19
            stage_r[i] <= 8'h00;
            valid_r[i] <= 1'b0;
         end else begin
            if (mem_if.commit && valid_r[i]) begin
               page_r[i] <= stage_r[i];
            end
            if (mem_if.stage_clr) begin
               valid_r[i] <= 1'b0;
            end else if (mem_if.wr_en && mem_if.wr_addr == 8'(i)) begin
               valid_r[i] <= 1'b1;
               stage_r[i] <= mem_if.wr_data;
            end
         end
      end
   end

   assign mem_if.rd_data = page_r[mem_if.rd_addr];
endmodule : idp_page_store

// ===== verilog/idp_pkg.sv
// Constants, opcodes and state types for the identification page access block.
// Assumes a 100 MHz core clock and an SPI mode 0 link sampled by that clock.
//
// Overview of operation
// RULE1: Separate 256-byte page, writable, permanently lockable. The code clears the lock flag on reset.
// RULE2: Page read uses address bits 7..0.
// RULE3: Read steps address after every byte.
// RULE4: Host keeps reads within the page.
// RULE5: Chip select rise ends read anywhere.
// RULE6: Page read refused during write cycle.
// RULE7: Page write targets byte address bits 7..0.
// RULE8: Lock status read needs page select one.
// RULE9: Lock flag returned in bit zero.
// RULE10: Lock status byte repeats without stepping.
// RULE11: Lock needs prior write enable.
// RULE12: Lock data byte must have bit one.
// RULE13: Chip select rises right after eighth bit.
// RULE14: Valid lock starts self-timed write cycle.
// RULE15: Lock discarded: busy, full protect, misaligned.
// RULE16: After reset wait for chip select fall.
// RULE17: Reset clears write enable and busy.
// RULE18: Protect bits kept outside, non-volatile.
// RULE19: Delivered page reads all ones.
// RULE20: Write cycle end clears busy flag.
// RULE21: Page write refused if locked, disabled, busy.
// RULE22: Page write wraps within the page.
package idp_pkg;
   localparam logic [7:0]  OP_SET_WRITE_LATCH = 8'h06;
   localparam logic [7:0]  OP_ID_READ         = 8'h83;
   localparam logic [7:0]  OP_ID_WRITE        = 8'h82;
   localparam int          ADDR_BITS          = 24;
   localparam int          PAGE_SELECT_POS    = 10;
   localparam int          LOCK_DATA_POS      = 1;
   localparam logic [7:0]  ERASED_BYTE        = 8'hff;
   localparam int          PAGE_BYTES         = 256;
   localparam int          CORE_CLK_MHZ       = 100;
   localparam int          SELF_TIMED_WRITE_TIME_US = 5;
   localparam int          WRITE_CYCLES = SELF_TIMED_WRITE_TIME_US * CORE_CLK_MHZ;

   typedef enum logic [2:0] {
      PH_IDLE    = 3'b000,
      PH_CMD     = 3'b001,
      PH_ADDR    = 3'b010,
      PH_RD_DATA = 3'b011,
      PH_RD_LOCK = 3'b100,
      PH_WR_DATA = 3'b101,
      PH_DISCARD = 3'b110
   } idp_phase_e;
endpackage : idp_pkg
